//--- verilog/vrs_cfg.svh
// Constants of the voltage-identification reference stepper.
// Assumes inclusion by bare name from the package and modules.
`ifndef VRS_CFG_SVH
`define VRS_CFG_SVH

// Code width and the reserved no-load code
`define VRS_CODE_W 5
`define VRS_CODE_NOLOAD 5'h1F
// Reference expressed in millivolts
`define VRS_REF_W 11
`define VRS_REF_TOP_MV 11'h60E
`define VRS_REF_BOTTOM_MV 11'h320
`define VRS_STEP_MV 11'h019
// Switching cycles per reference step
`define VRS_CYC_PER_STEP 2'h2

`endif

//--- verilog/vrs_pkg.sv
// Types shared by the reference stepper files.
// Assumes vrs_cfg.svh is on the include path.
`include "vrs_cfg.svh"

package vrs_pkg;
    // Identification code as sampled from the load
    typedef logic [`VRS_CODE_W-1:0] vrs_code_t;
    // Reference level in millivolts
    typedef logic [`VRS_REF_W-1:0] vrs_ref_t;
    // Stepper states
    typedef enum logic [1:0] {
        VRS_IDLE,
        VRS_SETTLE,
        VRS_RAMP,
        VRS_OFF
    } vrs_state_e;
    // Output bundle toward the analog reference
    typedef struct packed {
        vrs_ref_t ref_mv;
        logic shutdown;
        logic ramping;
    } vrs_out_s;
endpackage : vrs_pkg

//--- verilog/vrs_code_decode.sv
// Decoder from identification code to reference millivolts.
// Assumes a code that has already been sampled; output is registered.
`timescale 1ns/1ps
`default_nettype none
`include "vrs_cfg.svh"

module vrs_code_decode (
    input wire logic clk,
    input wire logic rstn,
    input wire vrs_pkg::vrs_code_t code,
    output vrs_pkg::vrs_ref_t level_mv
);
    import vrs_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Top level minus 25 mV per code step; no-load code parks at bottom
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_mv <= `VRS_REF_TOP_MV;
        end else if (code == `VRS_CODE_NOLOAD) begin
            level_mv <= `VRS_REF_BOTTOM_MV;
        end else begin
            level_mv <= `VRS_REF_TOP_MV - vrs_ref_t'(code * `VRS_STEP_MV);
        end
    end
endmodule : vrs_code_decode

`default_nettype wire

//--- verilog/vrs_stepper.sv
// Voltage-identification reference stepper.
// Assumes code bits and the first-phase pulse level are synchronous to clk; pulse ends are detected here.
//
// How it works
// (R1) Code zero 1.550 V, minus 25 mV per count
// (R2) All-ones code means shutdown; others restart
// (R3) Code change registered within one-two cycles
// (R4) Code must stay stable before ramping
// (R5) Step 25 mV every two switching cycles
// (R6) Sample code only at cycle start
// (R7) Cycle bounded by first phase pulse ends
// (R8) Downward steps match upward size and rate
`timescale 1ns/1ps
`default_nettype none
`include "vrs_cfg.svh"

module vrs_stepper (
    input wire logic clk,
    input wire logic rstn,
    input wire vrs_pkg::vrs_code_t voltage_id_code,
    input wire logic first_phase_pulse,
    output vrs_pkg::vrs_out_s dac_out
);
    import vrs_pkg::*;

    // ------------------------------------------------------------
    // Switching-cycle timebase
    // ------------------------------------------------------------
    logic pulse_d; // Previous pulse level
    logic cycle_start; // One clk pulse at each cycle boundary

    // (R7) Falling edge ends pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_d <= 1'b0;
        end else begin
            pulse_d <= first_phase_pulse;
        end
    end
    assign cycle_start = pulse_d & ~first_phase_pulse;

    // ------------------------------------------------------------
    // Code sampling
    // ------------------------------------------------------------
    vrs_code_t code_smp; // Code seen at the last boundary
    vrs_code_t code_prev; // Code seen one boundary earlier
    logic smp_valid; // At least one sample taken since reset

    // (R6) Boundary-only sampling
    // (R3) Registered at next boundary
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            code_smp <= 5'h00;
            code_prev <= 5'h00;
            smp_valid <= 1'b0;
        end else if (cycle_start) begin
            code_smp <= voltage_id_code;
            code_prev <= code_smp;
            smp_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------
    vrs_ref_t target_mv; // Level selected by the sampled code

    // (R1) Code to level
    vrs_code_decode u_decode (
        .clk(clk),
        .rstn(rstn),
        .code(code_smp),
        .level_mv(target_mv)
    );

    // ------------------------------------------------------------
    // Stepper state machine
    // ------------------------------------------------------------
    vrs_state_e state; // Current state
    vrs_ref_t ref_mv; // Reference now driven
    logic [1:0] cyc_cnt; // Cycles since last step
    logic stable; // Code unchanged over one whole cycle
    logic noload; // Sampled code is the no-load request

    assign stable = smp_valid && (code_smp == code_prev);
    assign noload = (code_smp == `VRS_CODE_NOLOAD);

    // Reference and state move only on boundaries, so ramp pace tracks fs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= VRS_IDLE;
            ref_mv <= `VRS_REF_TOP_MV;
            cyc_cnt <= 2'h0;
        end else if (cycle_start) begin
            case (state)
                VRS_IDLE: begin
                    // (R2) Enter shutdown
                    if (noload) begin
                        state <= VRS_OFF;
                    end else if (code_smp != code_prev) begin
                        state <= VRS_SETTLE;
                    end else if (ref_mv != target_mv) begin
                        state <= VRS_SETTLE;
                    end
                end
                VRS_SETTLE: begin
                    // (R4) Wait for stability
                    if (noload) begin
                        state <= VRS_OFF;
                    end else if (stable) begin
                        state <= VRS_RAMP;
                        cyc_cnt <= 2'h0;
                    end
                end
                VRS_RAMP: begin
                    if (noload) begin
                        state <= VRS_OFF;
                    end else if (!stable) begin
                        // New code mid-ramp restarts the settle wait
                        state <= VRS_SETTLE;
                    end else if (ref_mv == target_mv) begin
                        // (R5) Stop at target
                        state <= VRS_IDLE;
                    end else if (cyc_cnt == `VRS_CYC_PER_STEP - 2'h1) begin
                        cyc_cnt <= 2'h0;
                        // (R5) One step per two cycles
                        if (ref_mv < target_mv) begin
                            ref_mv <= ref_mv + `VRS_STEP_MV;
                        end else begin
                            // (R8) Downward same step
                            ref_mv <= ref_mv - `VRS_STEP_MV;
                        end
                    end else begin
                        cyc_cnt <= cyc_cnt + 2'h1;
                    end
                end
                VRS_OFF: begin
                    // (R2) Restart on other code; ramp from held level
                    if (!noload) begin
                        state <= VRS_SETTLE;
                    end
                end
                default: begin
                    state <= VRS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One driver for the whole bundle keeps strict tools content
    assign dac_out = '{ref_mv: ref_mv, shutdown: (state == VRS_OFF), ramping: (state == VRS_RAMP)};
endmodule : vrs_stepper

`default_nettype wire

//--- test/vrs_load_model.sv
// Load side: code lines and first-phase pulse.
// Code lines follow the bench request; pulse period is four clocks.
`timescale 1ns/1ps
`default_nettype none
module vrs_load_model (
    input wire logic clk,
    input wire logic rstn,
    input wire vrs_pkg::vrs_code_t req,
    output vrs_pkg::vrs_code_t code,
    output logic pulse
);
    import vrs_pkg::*;
    logic [1:0] cnt; // Phase within one switching cycle
    always_ff @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    assign pulse = ~cnt[1]; // High two clocks, low two
    assign code = req; // Lines move as soon as the load asks
endmodule : vrs_load_model
`default_nettype wire

//--- test/vrs_stepper_props.sv
// Checker on the stepper ports.
// Bound to vrs_stepper from the bench top.
`timescale 1ns/1ps
`default_nettype none
module vrs_stepper_props (
    input wire logic clk,
    input wire logic rstn,
    input wire vrs_pkg::vrs_code_t voltage_id_code,
    input wire logic first_phase_pulse,
    input wire vrs_pkg::vrs_out_s dac_out
);
    import vrs_pkg::*;
    logic pp; // Pulse one edge ago
    logic cs; // Cycle boundary seen this edge
    vrs_code_t last; // Code taken at last boundary
    vrs_ref_t r; // Short alias for the level
    assign cs = pp & ~first_phase_pulse;
    assign r = dac_out.ref_mv;
    // Follow boundaries the way the stepper sees them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pp <= 1'b0;
            last <= 5'h00;
        end else begin
            pp <= first_phase_pulse;
            last <= cs ? voltage_id_code : last;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ref_range: assert property (r >= 11'h320 && r <= 11'h60E)
        else $error("level out of range");
    a_step_size: assert property (!$stable(r) |-> r - $past(r) == 11'h019 || $past(r) - r == 11'h019)
        else $error("bad step size");
    a_step_boundary: assert property (!$stable(r) |-> $past(cs))
        else $error("step off boundary");
    a_step_ramping: assert property (!$stable(r) |-> $past(dac_out.ramping))
        else $error("step while not ramping");
    a_ramp_boundary: assert property ($rose(dac_out.ramping) |-> $past(cs))
        else $error("ramp start off boundary");
    a_shut_enter: assert property ($rose(dac_out.shutdown) |-> $past(cs) && $past(last) == 5'h1F)
        else $error("bad shutdown entry");
    a_shut_leave: assert property ($fell(dac_out.shutdown) |-> $past(cs) && $past(last) != 5'h1F)
        else $error("bad shutdown exit");
    a_shut_hold: assert property (dac_out.shutdown && $past(dac_out.shutdown) |-> $stable(r))
        else $error("level moved in shutdown");
endmodule : vrs_stepper_props
`default_nettype wire

//--- test/tb.sv
// Bench top for the stepper.
// Needs the load model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    import vrs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    vrs_code_t req = 5'h00; // Code the load asks for
    vrs_code_t code;
    logic pulse;
    vrs_out_s dac;
    int err_count = 0;
    int n_tests = 0;
    int ticks = 0;
    initial forever #50 clk = ~clk;
    vrs_load_model i_vrs_load_model (.clk(clk), .rstn(rstn), .req(req), .code(code), .pulse(pulse));
    vrs_stepper i_vrs_stepper (.clk(clk), .rstn(rstn), .voltage_id_code(code), .first_phase_pulse(pulse), .dac_out(dac));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Cut a hang short well past the expected run
    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // Move to a code of n steps away and time the ramp
    task automatic go(input vrs_code_t c, input int n);
        int cyc = 0;
        vrs_ref_t tgt = 11'h60E - 11'h019 * c;
        req = c;
        while (dac.ref_mv !== tgt && cyc < 400) begin
            @(negedge clk);
            cyc++;
        end
        `CHK("level", tgt, dac.ref_mv)
        `CHK("ramp time", cyc > 8 * n + 8 && cyc <= 8 * n + 16, 1'b1)
        repeat (12) @(negedge clk);
        `CHK("ramping", 1'b0, dac.ramping)
        $display("move done");
    endtask : go
    // A code held only between boundaries is never taken
    task automatic t_glitch();
        @(posedge pulse);
        req = 5'h05;
        @(negedge clk);
        req = 5'h01;
        repeat (20) @(negedge clk);
        `CHK("glitch level", 11'h5F5, dac.ref_mv)
        $display("glitch done");
    endtask : t_glitch
    // No-load code, then wake on an ordinary code
    task automatic t_noload();
        int n = 0;
        req = 5'h1F;
        while (dac.shutdown !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK("shutdown", 1'b1, dac.shutdown)
        repeat (12) @(negedge clk);
        `CHK("held", 11'h320, dac.ref_mv)
        go(5'h1C, 2);
        `CHK("wake", 1'b0, dac.shutdown)
        $display("noload done");
    endtask : t_noload
    // A new code mid-ramp must still land on the newest level
    task automatic t_retarget();
        int n = 0;
        req = 5'h18;
        repeat (16) @(negedge clk);
        `CHK("mid ramp", 1'b1, dac.ramping)
        req = 5'h16;
        while (dac.ref_mv !== 11'h3E8 && n < 200) begin
            @(negedge clk);
            n++;
        end
        `CHK("retarget level", 11'h3E8, dac.ref_mv)
        $display("retarget done");
    endtask : t_retarget
    initial begin
        repeat (3) @(negedge clk);
        `CHK("reset level", 11'h60E, dac.ref_mv)
        `CHK("reset shut", 1'b0, dac.shutdown)
        rstn = 1'b1;
        go(5'h04, 4);
        go(5'h01, 3);
        t_glitch();
        go(5'h1E, 29);
        t_noload();
        t_retarget();
        tally_and_finish();
    end
endmodule : tb
bind vrs_stepper vrs_stepper_props i_vrs_stepper_props (.clk(clk), .rstn(rstn), .voltage_id_code(voltage_id_code),
    .first_phase_pulse(first_phase_pulse), .dac_out(dac_out));
`default_nettype wire
